// *** hw/demand_pkg.sv ***
// Constants, types and decode functions for the demand and energy metering block
// What this block does
// - Demand is thermal exponential or rolling window, chosen by a two-valued setting.
// - Time constant accepts only 5, 10, 15, 30 or 60 minutes.
// - Pickup is OFF or a threshold inside the range of the input's nominal.
// - Changing demand type or time constant clears all demand values.
// - Group switch clears demand only if new group's type or constant differs.
// - Changing pickup thresholds leaves demand values untouched.
// - Four alarms assert while their demand current exceeds its pickup.
// - Each alarm deasserts once its demand current falls back below pickup.
// - Demand and peak kept for currents and single/three-phase MW and MVAR.
// - Demand-clear command clears demand values.
// - Peak-clear command clears peaks, independently of demand values.
// - Rolling mode may withhold demand for up to one time constant.
// - Demand is recomputed on a tick of about two seconds.
// - Daily, peaks are saved, replacing stored values that the new peak exceeds.
// - After power loss, peaks saved at 23:50 the previous day are reloaded.
// - While fault input is asserted, peak recording is suspended.
// - Energy accumulates MWh and MVARh; energy-clear command clears all accumulators.
// - Single-phase energy is provided only with a wye voltage connection.
// - Energy accumulators update on the two-second tick.
// - Daily, energy accumulators overwrite the stored values.
// - After power loss, energy saved at 23:50 the previous day is reloaded.
// - Front-panel clears act exactly like the serial clear commands.
// - Thermal step response reaches ninety percent after one time constant.
// - Rolling mode averages 5-minute intervals; outputs mean of last constant/5.
package demand_pkg;

    localparam int CLK_HZ          = 200_000_000;
    localparam int TICK_MS         = 2000;
    localparam int TICK_CYCLES_DEF = (CLK_HZ / 1000) * TICK_MS;
    localparam int TICKS_PER_MIN   = 60_000 / TICK_MS;
    localparam int INTERVAL_MIN    = 5;
    localparam logic [7:0]  INTERVAL_TICKS = 8'(INTERVAL_MIN * TICKS_PER_MIN);
    localparam logic [15:0] DAY_TICKS      = 16'(24 * 60 * TICKS_PER_MIN);
    localparam logic [15:0] SAVE_TICK      = 16'((23 * 60 + 50) * TICKS_PER_MIN);

    localparam int NCH      = 8;
    localparam int NEN      = 4;
    localparam int MAX_SLOT = 12;
    // Channel order: phase, neutral, residual, negseq, MW1, MVAR1, MW3, MVAR3
    localparam int CH_MW1   = 4;

    // APB byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_GROUP0 = 8'h04;
    localparam logic [7:0] OFS_GROUP1 = 8'h08;
    localparam logic [7:0] OFS_THR0   = 8'h0C;
    localparam logic [7:0] OFS_CMD    = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_TOD    = 8'h24;
    localparam logic [7:0] OFS_DEM0   = 8'h40;
    localparam logic [7:0] OFS_PEAK0  = 8'h60;
    localparam logic [7:0] OFS_ENER0  = 8'h80;

    // Field positions
    localparam int CTRL_GROUP_BIT = 0;
    localparam int CTRL_NOM_LSB   = 1;
    localparam int CTRL_WYE_BIT   = 3;
    localparam int GRP_TC_LSB     = 8;
    localparam int THR_EN_BIT     = 16;
    localparam int CMD_DEM_BIT    = 0;
    localparam int CMD_PEAK_BIT   = 1;
    localparam int CMD_ENER_BIT   = 2;

    // Reset values
    localparam logic [31:0] CTRL_RST  = 32'h0000_0008;
    localparam logic [5:0]  TC_RST    = 6'h0F;

    // Pickup ranges per nominal, in the units of the current samples
    localparam logic [15:0] THR5_MIN  = 16'h0032;
    localparam logic [15:0] THR5_MAX  = 16'h0640;
    localparam logic [15:0] THR1_MIN  = 16'h000A;
    localparam logic [15:0] THR1_MAX  = 16'h0140;
    localparam logic [15:0] THRS_MIN  = 16'h0005;
    localparam logic [15:0] THRS_MAX  = 16'h00A0;

    typedef struct packed {
        logic [NCH-1:0][15:0] value;
    } sample_type;

    typedef struct packed {
        logic       rolling;
        logic [5:0] tc_min;
    } group_type;

    typedef struct packed {
        logic        en;
        logic [15:0] value;
    } thr_type;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_UPDATE  = 2'b01,
        ST_SAVE    = 2'b11,
        ST_RESTORE = 2'b10
    } state_type;

    function automatic logic [3:0] tc_slots(input logic [5:0] tc);
        case (tc)
            6'h05:   tc_slots = 4'h1;
            6'h0A:   tc_slots = 4'h2;
            6'h0F:   tc_slots = 4'h3;
            6'h1E:   tc_slots = 4'h6;
            6'h3C:   tc_slots = 4'hC;
            default: tc_slots = 4'h0;
        endcase
    endfunction

    // Per-tick gain 1-0.1^(1/N) in Q16, N ticks per time constant
    function automatic logic [15:0] therm_gain(input logic [5:0] tc);
        case (tc)
            6'h05:   therm_gain = 16'h03E6;
            6'h0A:   therm_gain = 16'h01F5;
            6'h0F:   therm_gain = 16'h014E;
            6'h1E:   therm_gain = 16'h00A7;
            default: therm_gain = 16'h0054;
        endcase
    endfunction

    // 2^32 / (interval ticks * window slots), rounded up so whole averages come out exact
    function automatic logic [24:0] roll_recip(input logic [5:0] tc);
        case (tc)
            6'h05:   roll_recip = 25'h1B4E81C;
            6'h0A:   roll_recip = 25'h0DA740E;
            6'h0F:   roll_recip = 25'h091A2B4;
            6'h1E:   roll_recip = 25'h048D15A;
            default: roll_recip = 25'h02468AD;
        endcase
    endfunction

    function automatic logic thr_in_range(input logic [1:0] nom, input logic [15:0] v);
        case (nom)
            2'h1:    thr_in_range = (v >= THR1_MIN) && (v <= THR1_MAX);
            2'h2:    thr_in_range = (v >= THRS_MIN) && (v <= THRS_MAX);
            default: thr_in_range = (v >= THR5_MIN) && (v <= THR5_MAX);
        endcase
    endfunction

endpackage

// *** hw/demand_energy_metering.sv ***
// Demand, peak demand and energy metering with an APB register slave
module demand_energy_metering
    import demand_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_reset,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Averaged measurements, same clock domain
    input  wire sample_type  i_sample,
    // Asynchronous pins
    input  wire logic        i_fault,
    input  wire logic [2:0]  i_panel_clear,
    input  wire logic        i_power_restore,
    // Demand pickup alarms: phase, neutral, residual, negseq
    output logic      [3:0]  o_alarm
);

    // Pin synchronisers
    logic [4:0]  sync1_r, sync2_r, sync3_r;
    logic        fault_s;
    logic [2:0]  panel_evt;
    logic        restore_evt;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
            sync3_r <= 5'h00;
        end else begin
            sync1_r <= {i_power_restore, i_panel_clear, i_fault};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    assign fault_s     = sync2_r[0];
    assign panel_evt   = sync2_r[3:1] & ~sync3_r[3:1];
    assign restore_evt = sync2_r[4] & ~sync3_r[4];

    // APB handshake: decode in setup, answer in first access cycle
    logic        setup, commit;
    logic        pready_r, pslverr_r;
    logic [31:0] prdata_r;

    assign setup  = i_psel & ~i_penable;
    assign commit = i_psel & i_penable & pready_r;

    // Settings and commands
    logic [31:0] ctrl_r;
    group_type   group_r [2];
    thr_type     thr_r [4];
    logic [2:0]  cmd_r;
    group_type   eff, applied_r;
    logic [3:0]  slots;
    logic        wye;

    assign eff   = group_r[ctrl_r[CTRL_GROUP_BIT]];
    assign slots = tc_slots(applied_r.tc_min);
    assign wye   = ctrl_r[CTRL_WYE_BIT];

    // Metering state
    logic [31:0] tick_full_r;
    logic        tick_r;
    state_type   state_r;
    logic [15:0] tod_r;
    logic [31:0] dem_r [NCH];
    logic [15:0] peak_r [NCH];
    logic [23:0] isum_r [NCH];
    logic [27:0] win_r [NCH];
    logic [23:0] mem_r [NCH][MAX_SLOT];
    logic [3:0]  ptr_r, fill_r;
    logic [7:0]  itick_r;
    logic [47:0] ener_r [NEN];
    logic [15:0] nv_peak_r [NCH];
    logic [47:0] nv_ener_r [NEN];
    logic        clr_dem, clr_peak, clr_ener, upd, ivl_end;
    logic [3:0]  old_idx;

    assign clr_dem  = cmd_r[CMD_DEM_BIT] | panel_evt[0] | (eff != applied_r);
    assign clr_peak = cmd_r[CMD_PEAK_BIT] | panel_evt[1];
    assign clr_ener = cmd_r[CMD_ENER_BIT] | panel_evt[2];
    assign upd      = (state_r == ST_UPDATE);
    assign ivl_end  = (itick_r == INTERVAL_TICKS - 8'h01);
    assign old_idx  = (ptr_r >= slots) ? ptr_r - slots : 4'(ptr_r + 4'(MAX_SLOT) - slots);

    // Register write decode and error check
    logic        wr_err, rd_err;
    logic [31:0] rd_val;
    logic [7:0]  a_idx;

    always_comb begin
        a_idx  = i_paddr - OFS_THR0;
        wr_err = 1'b0;
        if (i_paddr == OFS_GROUP0 || i_paddr == OFS_GROUP1) begin
            wr_err = (tc_slots(i_pwdata[GRP_TC_LSB +: 6]) == 4'h0);
        end else if (i_paddr >= OFS_THR0 && i_paddr < OFS_CMD && i_paddr[1:0] == 2'b00) begin
            wr_err = i_pwdata[THR_EN_BIT]
                && !thr_in_range(ctrl_r[CTRL_NOM_LSB +: 2], i_pwdata[15:0]);
        end else if (i_paddr != OFS_CTRL && i_paddr != OFS_CMD && i_paddr != OFS_TOD) begin
            wr_err = 1'b1;
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        if (i_paddr[1:0] != 2'b00) begin
            rd_err = 1'b1;
        end else if (i_paddr >= OFS_ENER0) begin
            rd_err = (i_paddr[6:5] != 2'b00);
            if (!rd_err && (wye || i_paddr[4] == 1'b1)) begin
                rd_val = i_paddr[2] ? {16'h0000, ener_r[i_paddr[4:3]][47:32]}
                                    : ener_r[i_paddr[4:3]][31:0];
            end
        end else if (i_paddr >= OFS_PEAK0) begin
            rd_val = {16'h0000, peak_r[i_paddr[4:2]]};
        end else if (i_paddr >= OFS_DEM0) begin
            rd_val = {16'h0000, dem_r[i_paddr[4:2]][31:16]};
        end else begin
            case (i_paddr)
                OFS_CTRL:   rd_val = ctrl_r;
                OFS_GROUP0: rd_val = {18'h0, group_r[0].tc_min, 7'h0, group_r[0].rolling};
                OFS_GROUP1: rd_val = {18'h0, group_r[1].tc_min, 7'h0, group_r[1].rolling};
                OFS_CMD:    rd_val = 32'h0000_0000;
                OFS_STATUS: rd_val = {26'h0, (fill_r >= slots), fault_s, o_alarm};
                OFS_TOD:    rd_val = {16'h0000, tod_r};
                default: begin
                    if (i_paddr >= OFS_THR0 && i_paddr < OFS_CMD) begin
                        rd_val = {15'h0, thr_r[a_idx[3:2]]};
                    end else begin
                        rd_err = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup & (i_pwrite ? wr_err : rd_err);
            prdata_r  <= (setup && !i_pwrite && !rd_err) ? rd_val : 32'h0000_0000;
        end
    end

    assign o_prdata  = prdata_r;
    assign o_pready  = pready_r;
    assign o_pslverr = pslverr_r;

    // Settings; a rejected write is not stored. Threshold writes never touch demand.
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            ctrl_r    <= CTRL_RST;
            group_r   <= '{default: '{rolling: 1'b0, tc_min: TC_RST}};
            thr_r     <= '{default: '0};
            cmd_r     <= 3'h0;
            applied_r <= '{rolling: 1'b0, tc_min: TC_RST};
        end else begin
            applied_r <= eff;
            cmd_r     <= 3'h0;
            if (commit && i_pwrite && !pslverr_r) begin
                case (i_paddr)
                    OFS_CTRL:   ctrl_r <= {28'h0, i_pwdata[3:0]};
                    OFS_GROUP0: group_r[0] <= {i_pwdata[0], i_pwdata[GRP_TC_LSB +: 6]};
                    OFS_GROUP1: group_r[1] <= {i_pwdata[0], i_pwdata[GRP_TC_LSB +: 6]};
                    OFS_CMD:    cmd_r <= i_pwdata[2:0];
                    default: begin
                        if (i_paddr >= OFS_THR0 && i_paddr < OFS_CMD) begin
                            thr_r[a_idx[3:2]] <= i_pwdata[16:0];
                        end
                    end
                endcase
            end
        end
    end

    // Two-second tick; registered so the sequencer sees a clean one-cycle strobe
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            tick_full_r <= 32'h0000_0000;
            tick_r      <= 1'b0;
        end else begin
            tick_r      <= (tick_full_r == 32'(TICK_CYCLES - 1));
            tick_full_r <= (tick_full_r == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_full_r + 32'h1;
        end
    end

    // Sequencer: update on tick, daily save at the save time, reload after power return
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_r <= ST_IDLE;
            tod_r   <= 16'h0000;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (restore_evt) begin
                        state_r <= ST_RESTORE;
                    end else if (tick_r) begin
                        state_r <= ST_UPDATE;
                    end
                end
                ST_UPDATE: begin
                    tod_r   <= (tod_r == DAY_TICKS - 16'h1) ? 16'h0 : tod_r + 16'h1;
                    state_r <= (tod_r == SAVE_TICK) ? ST_SAVE : ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
            // Restore strobe lasts one cycle, so it must win in every state
            if (restore_evt) begin
                state_r <= ST_RESTORE;
            end
            if (commit && i_pwrite && !pslverr_r && i_paddr == OFS_TOD) begin
                tod_r <= i_pwdata[15:0];
            end
        end
    end

    // Demand arithmetic
    logic [31:0] therm_nxt [NCH];
    logic [23:0] isum_fin [NCH];
    logic [27:0] win_nxt [NCH];
    logic [15:0] roll_avg [NCH];

    always_comb begin
        logic signed [32:0] diff;
        logic signed [49:0] prod;
        logic signed [33:0] sum;
        logic [52:0]        prodr;
        diff  = '0;
        prod  = '0;
        sum   = '0;
        prodr = '0;
        for (int i = 0; i < NCH; i++) begin
            diff = $signed({1'b0, i_sample.value[i], 16'h0000}) - $signed({1'b0, dem_r[i]});
            prod = diff * $signed({1'b0, therm_gain(applied_r.tc_min)});
            sum  = $signed({2'b00, dem_r[i]}) + $signed(prod[49:16]);
            therm_nxt[i] = sum[33] ? 32'h0000_0000 : sum[31:0];
            isum_fin[i]  = isum_r[i] + 24'(i_sample.value[i]);
            win_nxt[i]   = win_r[i] + {4'h0, isum_fin[i]} - {4'h0, mem_r[i][old_idx]};
            prodr        = 53'(win_nxt[i]) * 53'(roll_recip(applied_r.tc_min));
            roll_avg[i]  = prodr[47:32];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset || clr_dem) begin
            dem_r   <= '{default: '0};
            isum_r  <= '{default: '0};
            win_r   <= '{default: '0};
            mem_r   <= '{default: '{default: '0}};
            ptr_r   <= 4'h0;
            fill_r  <= 4'h0;
            itick_r <= 8'h00;
        end else if (upd) begin
            if (!applied_r.rolling) begin
                dem_r <= therm_nxt;
            end else begin
                itick_r <= ivl_end ? 8'h00 : itick_r + 8'h01;
                for (int i = 0; i < NCH; i++) begin
                    isum_r[i] <= ivl_end ? 24'h0 : isum_fin[i];
                    if (ivl_end) begin
                        mem_r[i][ptr_r] <= isum_fin[i];
                        win_r[i]        <= win_nxt[i];
                        if (fill_r + 4'h1 >= slots) begin
                            dem_r[i] <= {roll_avg[i], 16'h0000};
                        end
                    end
                end
                if (ivl_end) begin
                    ptr_r  <= (ptr_r == 4'(MAX_SLOT - 1)) ? 4'h0 : ptr_r + 4'h1;
                    fill_r <= (fill_r >= slots) ? fill_r : fill_r + 4'h1;
                end
            end
        end
    end

    // Peaks and their nonvolatile copy
    always_ff @(posedge i_clock) begin
        if (i_reset || clr_peak) begin
            peak_r <= '{default: '0};
        end else if (state_r == ST_RESTORE) begin
            peak_r <= nv_peak_r;
        end else if (upd && !fault_s) begin
            for (int i = 0; i < NCH; i++) begin
                if (dem_r[i][31:16] > peak_r[i]) begin
                    peak_r[i] <= dem_r[i][31:16];
                end
            end
        end
    end

    // Backing store is cleared only by the cold reset, never by a restore
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            nv_peak_r <= '{default: '0};
            nv_ener_r <= '{default: '0};
        end else if (state_r == ST_SAVE) begin
            nv_ener_r <= ener_r;
            for (int i = 0; i < NCH; i++) begin
                if (peak_r[i] > nv_peak_r[i]) begin
                    nv_peak_r[i] <= peak_r[i];
                end
            end
        end
    end

    // Energy accumulators: sample times tick count, single-phase only with wye
    always_ff @(posedge i_clock) begin
        if (i_reset || clr_ener) begin
            ener_r <= '{default: '0};
        end else if (state_r == ST_RESTORE) begin
            ener_r <= nv_ener_r;
        end else if (upd) begin
            for (int k = 0; k < NEN; k++) begin
                if (k >= 2 || wye) begin
                    ener_r[k] <= ener_r[k] + 48'(i_sample.value[CH_MW1 + k]);
                end
            end
        end
    end

    // Pickup alarms; OFF keeps the alarm low
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_alarm <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                o_alarm[i] <= thr_r[i].en && (dem_r[i][31:16] > thr_r[i].value);
            end
        end
    end

    a_alarm_rise: assert property (@(posedge i_clock) disable iff (i_reset)
        (thr_r[0].en && dem_r[0][31:16] > thr_r[0].value) |=> o_alarm[0])
        else $error("phase alarm missed");

    a_alarm_fall: assert property (@(posedge i_clock) disable iff (i_reset)
        (dem_r[0][31:16] <= thr_r[0].value) |=> !o_alarm[0])
        else $error("phase alarm stuck high");

    a_setting_clear: assert property (@(posedge i_clock) disable iff (i_reset)
        (eff != applied_r) |=> (dem_r[3] == 32'h0 && fill_r == 4'h0))
        else $error("demand not cleared on setting change");

    a_thr_keeps: assert property (@(posedge i_clock) disable iff (i_reset)
        (commit && i_pwrite && i_paddr == OFS_THR0 && !clr_dem && !upd) |=> $stable(dem_r[0]))
        else $error("threshold write disturbed demand");

    a_peak_clear: assert property (@(posedge i_clock) disable iff (i_reset)
        clr_peak |=> (peak_r[0] == 16'h0 && peak_r[7] == 16'h0))
        else $error("peak not cleared");

    a_fault_hold: assert property (@(posedge i_clock) disable iff (i_reset)
        (fault_s && !clr_peak && state_r != ST_RESTORE) |=> $stable(peak_r[0]))
        else $error("peak moved during fault");

    a_peak_follow: assert property (@(posedge i_clock) disable iff (i_reset)
        (upd && !fault_s && !clr_peak && dem_r[0][31:16] > peak_r[0])
        |=> peak_r[0] == $past(dem_r[0][31:16]))
        else $error("peak not raised");

    a_roll_hold: assert property (@(posedge i_clock) disable iff (i_reset)
        (applied_r.rolling && fill_r < slots && !upd) |-> ##1 (dem_r[0] == 32'h0))
        else $error("rolling output before window filled");

    a_energy_clear: assert property (@(posedge i_clock) disable iff (i_reset)
        clr_ener |=> (ener_r[0] == 48'h0 && ener_r[3] == 48'h0))
        else $error("energy not cleared");

    a_delta_energy: assert property (@(posedge i_clock) disable iff (i_reset)
        (!wye && !clr_ener && state_r != ST_RESTORE) |=> $stable(ener_r[0]))
        else $error("single-phase energy moved without wye");

    a_save_peak: assert property (@(posedge i_clock) disable iff (i_reset)
        (state_r == ST_SAVE) |=> (nv_peak_r[4] >= $past(peak_r[4])))
        else $error("peak not saved");

endmodule

// *** tb/tb_demand_energy_metering.sv ***
// Self-checking bench for the demand and energy metering block over APB
module tb_demand_energy_metering
    import demand_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clock = 0, i_reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, fault = 0, restore = 0;
    logic [2:0]  panel = 3'h0;
    logic [3:0]  alarm;
    sample_type  smp = '0;
    int          miscompares = 0, n_checks = 0;
    // Short tick keeps the thermal and energy runs within a few thousand cycles
    demand_energy_metering #(.TICK_CYCLES(20)) u_dut (
        .i_clock(i_clock), .i_reset(i_reset), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_sample(smp), .i_fault(fault),
        .i_panel_clear(panel), .i_power_restore(restore), .o_alarm(alarm));
    initial begin
        forever #2.5 i_clock = ~i_clock;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask
    task automatic above(input string nm, input logic [31:0] lim);
        n_checks++;
        if ((rd > lim) !== 1'b1) begin
            $display("ERROR %s expected above %h seen %h", nm, lim, rd);
            miscompares++;
        end
    endtask
    // Request is held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic xe);
        @(posedge i_clock);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge i_clock);
        penable <= 1;
        do begin
            @(posedge i_clock);
        end while (pready !== 1'b1);
        rd = prdata;
        chk("pslverr", {31'h0, xe}, {31'h0, pslverr});
        psel <= 0; penable <= 0;
    endtask
    task automatic ticks(input int n);
        repeat (n * 20 + 4) @(posedge i_clock);
    endtask
    initial begin
        repeat (20000) @(posedge i_clock);
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge i_clock);
        i_reset <= 0;
        apb(0, OFS_CTRL, 0, 0); chk("ctrl", CTRL_RST, rd);
        apb(0, OFS_GROUP0, 0, 0); chk("group0", {26'h0, TC_RST} << GRP_TC_LSB, rd);
        apb(0, 8'hF0, 0, 1);
        apb(1, OFS_GROUP0, 32'h0000_0700, 1);
        apb(1, OFS_THR0, 32'h0001_0640 + 32'h1, 1);
        apb(1, OFS_THR0, 32'h0001_0032, 0);
        apb(1, OFS_GROUP0, 32'h0000_0500, 0);
        smp.value[0] <= 16'h03E8;
        ticks(150);
        apb(0, OFS_DEM0, 0, 0); above("demand", 32'h37A);
        chk("alarm", 32'h1, {28'h0, alarm});
        apb(0, OFS_PEAK0, 0, 0); above("peak", 32'h32);
        apb(1, OFS_DEM0, 32'h0, 1);
        smp.value[0] <= 16'h0000;
        apb(1, OFS_CMD, 32'h1, 0);
        apb(0, OFS_DEM0, 0, 0); chk("demand", 0, rd);
        repeat (4) @(posedge i_clock);
        chk("alarm", 0, {28'h0, alarm});
        apb(0, OFS_PEAK0, 0, 0); above("peak", 32'h32);
        apb(1, OFS_CMD, 32'h2, 0);
        apb(0, OFS_PEAK0, 0, 0); chk("peak", 0, rd);
        fault <= 1;
        smp.value[0] <= 16'h03E8;
        ticks(10);
        apb(0, OFS_PEAK0, 0, 0); chk("peak", 0, rd);
        fault <= 0;
        smp.value[0] <= 16'h0000;
        apb(1, OFS_THR0, 32'h0001_0050, 0);
        apb(0, OFS_DEM0, 0, 0); above("demand", 32'h0);
        apb(1, OFS_GROUP0, 32'h0000_0A00, 0);
        apb(0, OFS_DEM0, 0, 0); chk("demand", 0, rd);
        smp.value[4] <= 16'hFFFF;
        smp.value[6] <= 16'hFFFF;
        ticks(20);
        apb(0, OFS_ENER0 + 8'h10, 0, 0); above("energy3", 32'h0);
        apb(1, OFS_TOD, {16'h0000, SAVE_TICK}, 0);
        ticks(2);
        apb(1, OFS_CTRL, 32'h0, 0);
        apb(0, OFS_ENER0, 0, 0); chk("energy1", 0, rd);
        smp <= '0;
        panel <= 3'h4;
        repeat (4) @(posedge i_clock);
        panel <= 3'h0;
        repeat (8) @(posedge i_clock);
        apb(0, OFS_ENER0 + 8'h10, 0, 0); chk("energy3", 0, rd);
        apb(1, OFS_CMD, 32'h3, 0);
        apb(0, OFS_PEAK0 + 8'h18, 0, 0); chk("peak6", 0, rd);
        restore <= 1;
        repeat (4) @(posedge i_clock);
        restore <= 0;
        repeat (8) @(posedge i_clock);
        apb(0, OFS_ENER0 + 8'h10, 0, 0); above("energy3", 32'h0);
        apb(0, OFS_PEAK0 + 8'h18, 0, 0); above("peak6", 32'h0);
        smp.value[0] <= 16'h03E8;
        smp.value[4] <= 16'h0100;
        apb(1, OFS_GROUP0, 32'h0000_0501, 0);
        ticks(100);
        apb(0, OFS_DEM0, 0, 0); chk("roll early", 0, rd);
        ticks(60);
        apb(0, OFS_DEM0, 0, 0); chk("roll", 32'h3E8, rd);
        chk("alarm", 32'h1, {28'h0, alarm});
        apb(1, OFS_GROUP1, 32'h0000_0501, 0);
        apb(1, OFS_CTRL, 32'h1, 0);
        apb(0, OFS_DEM0, 0, 0); chk("demand", 32'h3E8, rd);
        apb(1, OFS_GROUP0, 32'h0000_0A01, 0);
        apb(0, OFS_DEM0, 0, 0); chk("demand", 32'h3E8, rd);
        apb(1, OFS_CTRL, 32'h0, 0);
        apb(0, OFS_DEM0, 0, 0); chk("demand", 0, rd);
        wrap_up();
    end
endmodule
